// >>> sirq_pkg.sv
package sirq_pkg;

    // interrupt levels carried in frames 2..16, index = frame - 1
    localparam int NUM_IRQ = 15;
    localparam logic [14:0] IRQ_IDLE = 15'h7fff;
    localparam int SMI_IRQ = 2;

    // frame numbering on the serial line
    localparam logic [4:0] FRAME_ZERO = 5'h00;
    localparam logic [4:0] FRAME_STEP = 5'h01;
    localparam logic [4:0] FRAME_FIRST_IRQ = 5'h02;
    localparam logic [4:0] FRAME_LAST_IRQ = 5'h10;
    localparam logic [4:0] FRAME_MAX = 5'h1f;

    // low pulse widths in bus clocks
    localparam int LOW_CNT_W = 4;
    localparam logic [3:0] STOP_W_QUIET = 4'h2;
    localparam logic [3:0] STOP_W_CONT = 4'h3;
    localparam logic [3:0] START_W_MIN = 4'h4;
    localparam logic [3:0] START_W_MAX = 4'h8;

    // reset value of the word crossing into the link domain: disabled, all idle
    localparam logic [15:0] TO_LINK_RESET = 16'h7fff;
    localparam logic [2:0] TO_SYS_RESET = 3'h0;

    typedef enum logic [1:0] {
        SIRQ_IDLE,
        SIRQ_START,
        SIRQ_DATA,
        SIRQ_GAP
    } sirq_state_type;

    typedef enum logic [1:0] {
        SIRQ_PH_SAMPLE,
        SIRQ_PH_RECOVER,
        SIRQ_PH_TURN
    } sirq_phase_type;

endpackage

// >>> sirq_sync.sv
`timescale 1ns/1ns

// two-stage level synchroniser; only stage two is visible outside
module sirq_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    // destination clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // levels from the other domain
    input wire logic [WIDTH-1:0] d,
    // synchronised levels
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] hold;
    } sirq_sync_state_type;

    sirq_sync_state_type r;
    sirq_sync_state_type next_r;

    // meta feeds hold and nothing else
    always_comb
    begin
        next_r.meta = d;
        next_r.hold = r.meta;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            r <= {RESET_VAL, RESET_VAL};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign q = r.hold;

endmodule

// >>> sirq_pulse_meter.sv
`timescale 1ns/1ns

// measures the width of each low pulse on the serial line
module sirq_pulse_meter
#(
    parameter int CNT_W = 4
)
(
    // link clock and reset
    input wire logic bus_clock,
    input wire logic bus_reset_n,
    // observed line level
    input wire logic line,
    // clocks low so far, saturating
    output logic [CNT_W-1:0] low_width,
    // line high again after a low pulse
    output logic rise
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } sirq_meter_state_type;

    sirq_meter_state_type r;
    sirq_meter_state_type next_r;

    // saturate so a stuck-low line cannot wrap into a legal width
    always_comb
    begin
        next_r = r;
        if (line)
        begin
            next_r.cnt = '0;
        end
        else if (r.cnt != {CNT_W{1'b1}})
        begin
            next_r.cnt = r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge bus_clock)
    begin
        if (!bus_reset_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign low_width = r.cnt;
    assign rise = line && (r.cnt != '0);

endmodule

// >>> sirq_agent.sv
`timescale 1ns/1ns

module sirq_agent
(
    // system clock domain
    input wire logic clk,
    input wire logic rst_b,
    // interrupt levels, low means asserted
    input wire logic [15:1] irq_level,
    input wire logic system_mgmt_interrupt_n,
    input wire logic mgmt_interrupt_mask,
    input wire logic serial_irq_enable,
    // status back in the system domain
    output logic cycle_active,
    output logic quiet_mode,
    output logic start_width_error,
    // serial interrupt link
    input wire logic bus_clock,
    input wire logic bus_reset_n,
    input wire logic sirq_i,
    output logic sirq_o,
    output logic sirq_oe
);

    // system-side state: the levels as offered to the link
    typedef struct packed {
        logic enable;
        logic [15:1] level;
    } sirq_sys_state_type;

    // link-side state, all on bus_clock
    typedef struct packed {
        sirq_pkg::sirq_state_type state;
        sirq_pkg::sirq_phase_type phase;
        logic [4:0] frame;
        logic quiet;
        logic drove_low;
        logic oe;
        logic o;
        logic width_err;
        logic active;
        logic [15:1] reported;
    } sirq_link_state_type;

    // reset: line released, continuous mode, nothing reported low yet
    localparam sirq_link_state_type LINK_RESET = '{
        state: sirq_pkg::SIRQ_IDLE,
        phase: sirq_pkg::SIRQ_PH_TURN,
        frame: sirq_pkg::FRAME_ZERO,
        quiet: 1'b0,
        drove_low: 1'b0,
        oe: 1'b0,
        o: 1'b1,
        width_err: 1'b0,
        active: 1'b0,
        reported: sirq_pkg::IRQ_IDLE
    };

    // s runs on clk, r on bus_clock; only the synchronisers join them
    sirq_sys_state_type s;
    sirq_sys_state_type next_s;
    sirq_link_state_type r;
    sirq_link_state_type next_r;

    // crossing words and link-side helpers
    logic [15:0] to_link;
    logic [15:0] link_word;
    logic link_enable;
    logic [15:1] link_level;
    logic [2:0] to_sys;
    logic [2:0] sys_word;
    logic [sirq_pkg::LOW_CNT_W-1:0] low_width;
    logic line_rise;
    logic pending;
    logic [3:0] slot_idx;
    logic slot_valid;
    logic start_rise;
    logic stop_rise;
    logic start_bad;
    logic stop_quiet;
    logic may_start;

    // ------------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------------

    // slot three merges irq2 with the management interrupt unless masked;
    // registered here so no combinational glitch reaches the synchroniser
    always_comb
    begin
        next_s.enable = serial_irq_enable;
        next_s.level = irq_level;
        next_s.level[sirq_pkg::SMI_IRQ] = irq_level[sirq_pkg::SMI_IRQ]
            & (system_mgmt_interrupt_n | mgmt_interrupt_mask);
    end

    // one flop in the source domain: the synchroniser never sees gates
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s <= '{enable: 1'b0, level: sirq_pkg::IRQ_IDLE};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign to_link = {s.enable, s.level};

    // levels only cross; bits may skew by a clock, which is harmless for irqs
    sirq_sync #(
        .WIDTH(16),
        .RESET_VAL(sirq_pkg::TO_LINK_RESET)
    ) u_to_link (
        .clk(bus_clock),
        .rst_b(bus_reset_n),
        .d(to_link),
        .q(link_word)
    );

    // enable rides in the top bit of the crossing word
    assign link_enable = link_word[15];
    assign link_level = link_word[14:0];

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------

    // line is driven by the host on bus_clock, so it is sampled directly
    // the meter runs through data frames too, so every low run is measured
    sirq_pulse_meter #(
        .CNT_W(sirq_pkg::LOW_CNT_W)
    ) u_meter (
        .bus_clock(bus_clock),
        .bus_reset_n(bus_reset_n),
        .line(sirq_i),
        .low_width(low_width),
        .rise(line_rise)
    );

    // a level differs from what the host last saw from us
    assign pending = (link_level != r.reported);

    // self start only when enabled, in quiet mode and with news to send;
    // continuous mode leaves every start to the host
    assign may_start = link_enable && r.quiet && pending;

    // pulse classification at the rising edge of a low run; a sample low
    // lasts one clock, so a run of two or more during data is the stop
    always_comb
    begin
        start_rise = line_rise && (r.state == sirq_pkg::SIRQ_START);
        stop_rise = line_rise && (r.state == sirq_pkg::SIRQ_DATA)
            && (low_width >= sirq_pkg::STOP_W_QUIET);
        start_bad = (low_width < sirq_pkg::START_W_MIN)
            || (low_width > sirq_pkg::START_W_MAX);
        stop_quiet = (low_width == sirq_pkg::STOP_W_QUIET);
    end

    // slot of the frame the next clock belongs to; frame n carries irq n-1
    // frames past sixteen are ignored, so a long host cycle is harmless
    always_comb
    begin
        slot_idx = 4'h0;
        slot_valid = 1'b0;
        if ((r.phase == sirq_pkg::SIRQ_PH_TURN)
            && (r.frame >= sirq_pkg::FRAME_ZERO + sirq_pkg::FRAME_STEP)
            && (r.frame < sirq_pkg::FRAME_LAST_IRQ))
        begin
            slot_idx = r.frame[3:0];
            slot_valid = 1'b1;
        end
    end

    // one pass through the cycle; outputs are registered for the next clock
    // frame counter saturates so a missing stop cannot wrap into slots
    always_comb
    begin
        next_r = r;
        next_r.oe = 1'b0;
        next_r.o = 1'b1;
        unique case (r.state)
            sirq_pkg::SIRQ_IDLE, sirq_pkg::SIRQ_GAP:
            begin
                next_r.drove_low = 1'b0;
                if (!sirq_i)
                begin
                    // any agent, ourselves included, has begun a start frame
                    next_r.state = sirq_pkg::SIRQ_START;
                end
                else
                begin
                    next_r.state = sirq_pkg::SIRQ_IDLE;
                    // gap state lasts one clock, so this drives clock two after rise
                    if (may_start)
                    begin
                        next_r.oe = 1'b1;
                        next_r.o = 1'b0;
                    end
                end
            end
            sirq_pkg::SIRQ_START:
            begin
                // host holds the line; we never drive during the start pulse
                if (start_rise)
                begin
                    next_r.state = sirq_pkg::SIRQ_DATA;
                    next_r.phase = sirq_pkg::SIRQ_PH_TURN;
                    next_r.frame = sirq_pkg::FRAME_ZERO;
                    if (start_bad)
                    begin
                        next_r.width_err = 1'b1;
                    end
                end
            end
            sirq_pkg::SIRQ_DATA:
            begin
                unique case (r.phase)
                    sirq_pkg::SIRQ_PH_TURN:
                    begin
                        next_r.phase = sirq_pkg::SIRQ_PH_SAMPLE;
                        if (r.frame != sirq_pkg::FRAME_MAX)
                        begin
                            next_r.frame = r.frame + sirq_pkg::FRAME_STEP;
                        end
                    end
                    sirq_pkg::SIRQ_PH_SAMPLE:
                    begin
                        next_r.phase = sirq_pkg::SIRQ_PH_RECOVER;
                    end
                    sirq_pkg::SIRQ_PH_RECOVER:
                    begin
                        next_r.phase = sirq_pkg::SIRQ_PH_TURN;
                    end
                    default:
                    begin
                        next_r.phase = sirq_pkg::SIRQ_PH_TURN;
                    end
                endcase
                // remembers our own low for the recovery clock
                next_r.drove_low = 1'b0;
                // sample phase: low only for a low level, else tri-state
                if (slot_valid && link_enable)
                begin
                    next_r.reported[slot_idx] = link_level[slot_idx];
                    if (!link_level[slot_idx])
                    begin
                        next_r.oe = 1'b1;
                        next_r.o = 1'b0;
                        next_r.drove_low = 1'b1;
                    end
                end
                // recovery: push high only after our own low; turn releases
                if ((r.phase == sirq_pkg::SIRQ_PH_SAMPLE) && r.drove_low && link_enable)
                begin
                    next_r.oe = 1'b1;
                    next_r.o = 1'b1;
                end
                // sample lows last one clock, so two or more mean a stop frame
                if (stop_rise)
                begin
                    next_r.state = sirq_pkg::SIRQ_GAP;
                    next_r.quiet = stop_quiet;
                    next_r.oe = 1'b0;
                    next_r.o = 1'b1;
                    next_r.drove_low = 1'b0;
                end
            end
            default:
            begin
                next_r.state = sirq_pkg::SIRQ_IDLE;
            end
        endcase
        // registered so the crossing sees a clean level, not decoded state bits
        next_r.active = (next_r.state == sirq_pkg::SIRQ_START)
            || (next_r.state == sirq_pkg::SIRQ_DATA);
    end

    // reset releases the line and returns to continuous idle
    always_ff @(posedge bus_clock)
    begin
        if (!bus_reset_n)
        begin
            r <= LINK_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // pad drive straight from flops, no gates after them
    assign sirq_o = r.o;
    assign sirq_oe = r.oe;

    // status levels back to the system domain
    assign to_sys = {
        r.width_err,
        r.quiet,
        r.active
    };

    sirq_sync #(
        .WIDTH(3),
        .RESET_VAL(sirq_pkg::TO_SYS_RESET)
    ) u_to_sys (
        .clk(clk),
        .rst_b(rst_b),
        .d(to_sys),
        .q(sys_word)
    );

    // status lags the link by two system clocks
    assign cycle_active = sys_word[0];
    assign quiet_mode = sys_word[1];
    assign start_width_error = sys_word[2];

endmodule

// >>> sirq_checker.sv
`timescale 1ns/1ns

// watches slot timing, self start and stop decode at the link pins
module sirq_checker
(
    // clocks and resets
    input wire logic clk,
    input wire logic rst_b,
    input wire logic bus_clock,
    input wire logic bus_reset_n,
    // user side
    input wire logic serial_irq_enable,
    input wire logic quiet_mode,
    // link
    input wire logic sirq_i,
    input wire logic sirq_o,
    input wire logic sirq_oe
);
    logic [3:0] lowc;
    logic [5:0] pos;
    logic act;
    logic [4:0] dcnt;
    logic dl;

    // agent pulling the line low
    assign dl = sirq_oe & ~sirq_o;

    // low run length, clocks since start rise, cycle in progress
    always_ff @(posedge bus_clock)
    begin
        if (!bus_reset_n)
        begin
            lowc <= 4'h0;
            pos <= 6'h3f;
            act <= 1'b0;
        end
        else
        begin
            lowc <= sirq_i ? 4'h0 : ((lowc == 4'hf) ? lowc : lowc + 4'h1);
            pos <= (sirq_i && lowc >= 4'h4) ? 6'h01 : ((pos == 6'h3f) ? pos : pos + 6'h01);
            if (sirq_i && lowc >= 4'h4)
                act <= 1'b1;
            else if (sirq_i && lowc >= 4'h2)
                act <= 1'b0;
        end
    end

    // long enough disabled to cover the crossing and one frame
    always_ff @(posedge clk)
    begin
        if (!rst_b || serial_irq_enable)
            dcnt <= 5'h00;
        else if (dcnt != 5'h1f)
            dcnt <= dcnt + 5'h01;
    end

    recover_high_a: assert property (@(posedge bus_clock) disable iff (!bus_reset_n)
        sirq_oe && sirq_o |-> $past(dl)) else $error("high drive without low slot");
    turn_release_a: assert property (@(posedge bus_clock) disable iff (!bus_reset_n)
        sirq_oe && sirq_o |=> !sirq_oe) else $error("line not released at turn");
    slot_timing_a: assert property (@(posedge bus_clock) disable iff (!bus_reset_n)
        act && dl |-> pos >= 6'h05 && pos <= 6'h2f && pos % 3 == 2)
        else $error("low drive outside a sample slot");
    self_start_a: assert property (@(posedge bus_clock) disable iff (!bus_reset_n)
        !act && dl |-> quiet_mode ##1 !sirq_oe) else $error("bad self start");
    quiet_decode_a: assert property (@(posedge bus_clock) disable iff (!bus_reset_n)
        sirq_i && lowc == 4'h2 |-> ##[1:3] quiet_mode) else $error("quiet stop missed");
    cont_decode_a: assert property (@(posedge bus_clock) disable iff (!bus_reset_n)
        sirq_i && lowc == 4'h3 |-> ##[1:3] !quiet_mode) else $error("continuous stop missed");
    stop_gap_a: assert property (@(posedge bus_clock) disable iff (!bus_reset_n)
        sirq_i && act && lowc >= 4'h2 && lowc <= 4'h3 |=> !sirq_oe)
        else $error("drive in clock after stop");
    disabled_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        dcnt == 5'h1f |-> !sirq_oe) else $error("disabled agent drives");

    cover property (@(posedge bus_clock) disable iff (!bus_reset_n) act && dl);
    cover property (@(posedge bus_clock) disable iff (!bus_reset_n) !act && dl);
    cover property (@(posedge bus_clock) disable iff (!bus_reset_n) sirq_i && lowc == 4'h2);
endmodule

bind sirq_agent sirq_checker CHK (.clk(clk), .rst_b(rst_b), .bus_clock(bus_clock),
    .bus_reset_n(bus_reset_n), .serial_irq_enable(serial_irq_enable),
    .quiet_mode(quiet_mode), .sirq_i(sirq_i), .sirq_o(sirq_o), .sirq_oe(sirq_oe));

// >>> sirq_host_model.sv
`timescale 1ns/1ns

// host controller end of the serial interrupt link
module sirq_host_model
(
    // link clock and resolved line
    input wire logic bus_clock,
    input wire logic line,
    // host drive
    output logic host_oe,
    output logic host_o
);
    logic [16:1] seen;

    initial
    begin
        host_oe = 1'b0;
        host_o = 1'b1;
        seen = '0;
    end

    // start, frames 2 to 16 sampled 2 ns after the edge, stop; all after a rising edge
    task automatic cycle(input int sw, input int pw);
        @(posedge bus_clock);
        #1 host_oe = 1'b1;
        host_o = 1'b0;
        seen = '0;
        repeat (sw) @(posedge bus_clock);
        #1 host_o = 1'b1;
        @(posedge bus_clock);
        #1 host_oe = 1'b0;
        for (int k = 1; k < 50; k++)
        begin
            #1;
            if (k % 3 == 2 && k > 4 && line === 1'b0)
                seen[(k + 1) / 3] = 1'b1;
            @(posedge bus_clock);
            #1;
        end
        host_oe = 1'b1;
        host_o = 1'b0;
        repeat (pw) @(posedge bus_clock);
        #1 host_o = 1'b1;
        @(posedge bus_clock);
        #1 host_oe = 1'b0;
    endtask

    // look for an agent pulling the idle line low
    task automatic wait_start(output logic f);
        f = 1'b0;
        repeat (40)
        begin
            @(posedge bus_clock);
            #1;
            if (line === 1'b0)
            begin
                f = 1'b1;
                break;
            end
        end
    endtask
endmodule

// >>> test_serial_irq_slave_agent.sv
`timescale 1ns/1ns

// drives the agent against the host model
module test_serial_irq_slave_agent;
    logic clk, rst_b, bus_clock, bus_reset_n, smi_n, msk, en, f;
    logic [15:1] lvl;
    logic cyc_act, quiet, sw_err, sirq_o, sirq_oe, line, host_oe, host_o;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    sirq_agent DUT (.clk(clk), .rst_b(rst_b), .irq_level(lvl),
        .system_mgmt_interrupt_n(smi_n), .mgmt_interrupt_mask(msk),
        .serial_irq_enable(en), .cycle_active(cyc_act), .quiet_mode(quiet),
        .start_width_error(sw_err), .bus_clock(bus_clock), .bus_reset_n(bus_reset_n),
        .sirq_i(line), .sirq_o(sirq_o), .sirq_oe(sirq_oe));
    sirq_host_model HOST (.bus_clock(bus_clock), .line(line), .host_oe(host_oe),
        .host_o(host_o));

    // pulled up when nobody drives
    assign line = sirq_oe ? sirq_o : (host_oe ? host_o : 1'b1);

    // system clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // link clock, phase offset on purpose
    initial
    begin
        bus_clock = 1'b0;
        #3;
        forever #15 bus_clock = ~bus_clock;
    end

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // low levels expected in slots; frame three merges the management line
    function automatic logic [15:0] ex(input logic [15:1] l, input logic s, input logic m);
        l[2] = l[2] & (s | m);
        return {~l, 1'b0};
    endfunction

    task automatic setin(input logic [15:1] l, input logic s, m, e, input int w);
        @(posedge clk);
        #1 lvl = l;
        smi_n = s;
        msk = m;
        en = e;
        repeat (w) @(posedge clk);
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task t_reset;
        chk({11'h0, sirq_oe, sirq_o, cyc_act, quiet, sw_err}, 16'h0008);
        $display("reset test done");
    endtask

    task automatic slot_run(input logic [15:1] l, input logic s, m, input int sw);
        setin(l, s, m, 1'b1, 12);
        fork
            HOST.cycle(sw, 3);
            begin
                repeat (40) @(posedge clk);
                #1 chk({15'h0, cyc_act}, 16'h0001);
            end
        join
        chk(HOST.seen, ex(l, s, m));
        repeat (4) @(posedge clk);
        #1 chk({14'h0, cyc_act, sw_err}, 16'h0000);
    endtask

    task t_slots;
        slot_run(15'h7ffe, 1'b1, 1'b0, 4);
        slot_run(15'h2b5a, 1'b0, 1'b0, 8);
        slot_run(15'h6fff, 1'b0, 1'b1, 6);
        $display("slot test done");
    endtask

    task t_quiet;
        setin(15'h7fff, 1'b1, 1'b0, 1'b1, 12);
        HOST.cycle(4, 2);
        repeat (4) @(posedge clk);
        #1 chk({15'h0, quiet}, 16'h0001);
        setin(15'h7fef, 1'b1, 1'b0, 1'b1, 0);
        HOST.wait_start(f);
        chk({15'h0, f}, 16'h0001);
        HOST.cycle(3, 3);
        chk(HOST.seen, ex(15'h7fef, 1'b1, 1'b0));
        repeat (4) @(posedge clk);
        #1 chk({15'h0, quiet}, 16'h0000);
        setin(15'h7fff, 1'b1, 1'b0, 1'b1, 0);
        HOST.wait_start(f);
        chk({15'h0, f}, 16'h0000);
        HOST.cycle(4, 2);
        chk(HOST.seen, 16'h0000);
        HOST.wait_start(f);
        chk({15'h0, f}, 16'h0000);
        $display("quiet test done");
    endtask

    task t_disable;
        setin(15'h0000, 1'b0, 1'b0, 1'b0, 12);
        HOST.cycle(4, 2);
        chk(HOST.seen, 16'h0000);
        HOST.wait_start(f);
        chk({15'h0, f}, 16'h0000);
        setin(15'h7fff, 1'b1, 1'b0, 1'b1, 12);
        $display("disable test done");
    endtask

    // over-long host start sets the sticky flag; a mid-run reset clears it
    task t_bad_start;
        HOST.cycle(9, 3);
        chk(HOST.seen, 16'h0000);
        repeat (4) @(posedge clk);
        #1 chk({15'h0, sw_err}, 16'h0001);
        @(posedge bus_clock);
        #1 bus_reset_n = 1'b0;
        rst_b = 1'b0;
        repeat (3) @(posedge bus_clock);
        #1 bus_reset_n = 1'b1;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1 t_reset;
        $display("bad start test done");
    endtask

    initial
    begin
        lvl = 15'h7fff;
        smi_n = 1'b1;
        msk = 1'b0;
        en = 1'b1;
        rst_b = 1'b0;
        bus_reset_n = 1'b0;
        repeat (3) @(posedge bus_clock);
        #1 bus_reset_n = 1'b1;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1 t_reset;
        t_slots;
        t_quiet;
        t_disable;
        t_bad_start;
        test_done;
    end
endmodule
